// [rtl/csrs_pkg.sv]
// package: register map, fields, timing and carriers of the status/select block
package csrs_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
   localparam int ADDR_W = 8;

   // control word field positions
   localparam int CTRL_FUNC_BIT = 0;
   localparam int CTRL_POL_BIT = 1;
   localparam int CTRL_SEQ_BIT = 2;
   localparam int CTRL_SER_BIT = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // event bits of irq status and mask
   localparam int EVT_CONV_DONE = 0;
   localparam int EVT_FRAME = 1;
   localparam int EVT_READ = 2;
   localparam int EVT_W = 3;
   localparam logic [2:0] EVT_RST = 3'h0;

   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_CLK_PERIOD_PS = 50000;
   localparam int CCLK_CYCLES_I =
      (CONV_CLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   localparam logic [7:0] CCLK_CYCLES = CCLK_CYCLES_I[7:0];
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;

   localparam int DATA_W = 16;
   localparam logic [15:0] DATA_RST = 16'h0000;

   // host-side pins, as they arrive from the board
   typedef struct packed {
      logic select_or_frame_sync_in_n;
      logic rd_n;
      logic sel_a;
      logic sel_b;
   } csrs_host_pins_t;
   localparam csrs_host_pins_t PINS_IDLE = 4'hF;

   // event strobes from the converter core, same clock
   typedef struct packed {
      logic conv_start;
      logic pair_done;
      logic all_latched;
   } csrs_core_evt_t;

   // pin drivers towards the board
   typedef struct packed {
      logic status_out;
      logic data_oe;
      logic serial_data_out_a_oe;
      logic serial_data_out_b_oe;
   } csrs_pin_out_t;

endpackage

// [rtl/csrs_top.sv]
// status pin, select/frame-sync, read enable and serial-select logic with AHB-Lite control
//
// Summary of operation
// - busy behaviour: status goes active at conversion start and stays during conversion
// - busy ends when all six results are latched, inactive until next start
// - sequential mode: busy drops one conversion clock period per finished pair
// - interrupt behaviour: status set after conversion, held until result is read
// - polarity bit inverts active level of the status output in both behaviours
// - parallel mode: select low enables interface, activity ignored while high
// - serial mode: falling edge of select starts a frame transfer
// - parallel data driven only while read input is low
// - serial output B enabled while its select is high, disabled when low
module csrs_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // converter core
   input wire csrs_pkg::csrs_core_evt_t core_evt,
   input wire logic [csrs_pkg::DATA_W-1:0] result_data,
   // board pins
   input wire csrs_pkg::csrs_host_pins_t host_pins,
   output csrs_pkg::csrs_pin_out_t pin_out,
   output logic [csrs_pkg::DATA_W-1:0] data_out,
   output logic frame_start,
   output logic irq
);
   import csrs_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DIP = 2'b10
   } csrs_state_t;

   csrs_host_pins_t sync1_reg, sync2_reg, prev_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [EVT_W-1:0] irq_stat_reg, irq_mask_reg, evt_set;
   csrs_state_t state_reg, state_next;
   logic [CNT_W-1:0] dip_cnt_reg;
   logic int_pend_reg;
   logic status_pin_reg;
   logic [DATA_W-1:0] data_reg;
   logic frame_reg;
   logic wr_pend_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [31:0] rdata_next;

   logic func_bit, pol_bit, seq_bit, ser_bit;
   logic par_en, read_evt, fs_fall, busy_level, status_level;
   logic dip_start, wr_ctrl, wr_stat, wr_mask;

   assign func_bit = ctrl_reg[CTRL_FUNC_BIT];
   assign pol_bit = ctrl_reg[CTRL_POL_BIT];
   assign seq_bit = ctrl_reg[CTRL_SEQ_BIT];
   assign ser_bit = ctrl_reg[CTRL_SER_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; edges are taken from stage two only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= PINS_IDLE;
         sync2_reg <= PINS_IDLE;
         prev_reg <= PINS_IDLE;
      end else begin
         sync1_reg <= host_pins;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // select gates the read strobe, data capture and data enable in parallel mode; the status pin is not gated
   assign par_en = !ser_bit && !sync2_reg.select_or_frame_sync_in_n;
   assign read_evt = par_en && prev_reg.rd_n && !sync2_reg.rd_n;
   assign fs_fall = ser_bit && prev_reg.select_or_frame_sync_in_n && !sync2_reg.select_or_frame_sync_in_n;

   ////////////////////////////////////////////////////////////////////////////////
   // busy sequencing
   assign dip_start = seq_bit && core_evt.pair_done && !core_evt.all_latched;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (core_evt.conv_start) begin
               state_next = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (core_evt.all_latched) begin
               state_next = ST_IDLE;
            end else if (dip_start) begin
               state_next = ST_DIP;
            end
         end
         ST_DIP: begin
            if (core_evt.all_latched) begin
               state_next = ST_IDLE;
            end else if (dip_cnt_reg == CNT_ONE) begin
               state_next = ST_BUSY;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // dip length is one conversion clock period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dip_cnt_reg <= CNT_ZERO;
      end else if (state_reg == ST_BUSY && state_next == ST_DIP) begin
         dip_cnt_reg <= CCLK_CYCLES;
      end else if (dip_cnt_reg != CNT_ZERO) begin
         dip_cnt_reg <= dip_cnt_reg - CNT_ONE;
      end
   end

   assign busy_level = (state_reg == ST_BUSY);

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt behaviour: set wins over a clearing read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_pend_reg <= 1'b0;
      end else if (core_evt.all_latched) begin
         int_pend_reg <= 1'b1;
      end else if (read_evt || fs_fall) begin
         int_pend_reg <= 1'b0;
      end
   end

   assign status_level = func_bit ? int_pend_reg : busy_level;

   // pin level registered so it never glitches on a mode write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_pin_reg <= 1'b0;
      end else begin
         status_pin_reg <= status_level ^ pol_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // parallel data and output enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_reg <= DATA_RST;
      end else if (par_en && !sync2_reg.rd_n) begin
         data_reg <= result_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_reg <= 1'b0;
      end else begin
         frame_reg <= fs_fall;
      end
   end

   assign data_out = data_reg;
   assign frame_start = frame_reg;
   assign pin_out.status_out = status_pin_reg;
   // enables low means the pins float for other agents
   assign pin_out.data_oe = par_en && !sync2_reg.rd_n;
   assign pin_out.serial_data_out_a_oe = ser_bit && sync2_reg.sel_a;
   assign pin_out.serial_data_out_b_oe = ser_bit && sync2_reg.sel_b;

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states; writes land in the data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= CTRL_OFS;
      end else if (hready) begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         if (hsel && htrans[1]) begin
            addr_reg <= haddr[ADDR_W-1:0];
         end
      end
   end

   assign wr_ctrl = wr_pend_reg && (addr_reg == CTRL_OFS);
   assign wr_stat = wr_pend_reg && (addr_reg == IRQ_STAT_OFS);
   assign wr_mask = wr_pend_reg && (addr_reg == IRQ_MASK_OFS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= hwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_reg <= EVT_RST;
      end else if (wr_mask) begin
         irq_mask_reg <= hwdata[EVT_W-1:0];
      end
   end

   always_comb begin
      evt_set = EVT_RST;
      evt_set[EVT_CONV_DONE] = core_evt.all_latched;
      evt_set[EVT_FRAME] = fs_fall;
      evt_set[EVT_READ] = read_evt;
   end

   // write one to clear; a same-cycle event keeps its bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= EVT_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? hwdata[EVT_W-1:0] : EVT_RST)) | evt_set;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // reads are combinational off the latched address
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (addr_reg)
         CTRL_OFS: rdata_next[CTRL_W-1:0] = ctrl_reg;
         STAT_OFS: begin
            rdata_next[0] = busy_level;
            rdata_next[1] = int_pend_reg;
            rdata_next[2] = status_pin_reg;
            rdata_next[3] = sync2_reg.select_or_frame_sync_in_n;
            rdata_next[4] = sync2_reg.rd_n;
            rdata_next[5] = sync2_reg.sel_a;
            rdata_next[6] = sync2_reg.sel_b;
            rdata_next[7] = (state_reg == ST_DIP);
         end
         IRQ_STAT_OFS: rdata_next[EVT_W-1:0] = irq_stat_reg;
         IRQ_MASK_OFS: rdata_next[EVT_W-1:0] = irq_mask_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   assign hrdata = rdata_next;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_dip_begin;
      state_reg == ST_BUSY && dip_start;
   endsequence

   sequence s_dip_body;
      !busy_level && dip_cnt_reg == CCLK_CYCLES;
   endsequence

   a_busy_start: assert property (
      (state_reg == ST_IDLE && core_evt.conv_start && !func_bit)
      |=> busy_level ##1 (status_pin_reg == !pol_bit))
      else $error("busy not raised at conversion start");

   a_busy_end: assert property (
      (busy_level && core_evt.all_latched && !func_bit) |=> !busy_level
      ##1 ($past(func_bit) || status_pin_reg == $past(pol_bit)))
      else $error("busy not cleared after results latched");

   a_busy_stays_low: assert property (
      (state_reg == ST_IDLE && !core_evt.conv_start) |=> state_reg == ST_IDLE)
      else $error("busy rose without a conversion start");

   a_seq_dip_len: assert property (
      s_dip_begin |=> s_dip_body)
      else $error("pair dip did not start with full period");

   a_seq_dip_hold: assert property (
      (state_reg == ST_DIP && dip_cnt_reg > CNT_ONE && !core_evt.all_latched)
      |=> state_reg == ST_DIP)
      else $error("pair dip ended early");

   a_int_set: assert property (
      core_evt.all_latched |=> int_pend_reg)
      else $error("interrupt not set after conversion");

   a_int_hold: assert property (
      (int_pend_reg && !read_evt && !fs_fall) |=> int_pend_reg)
      else $error("interrupt dropped without a read");

   // both levels of the pin, so a stuck pin cannot pass
   a_pol_level: assert property (
      status_level |=> status_pin_reg == !$past(pol_bit))
      else $error("status pin active level wrong");

   a_pol_idle: assert property (
      !status_level |=> status_pin_reg == $past(pol_bit))
      else $error("status pin inactive level wrong");

   a_cs_gate: assert property (
      sync2_reg.select_or_frame_sync_in_n |-> !pin_out.data_oe && !read_evt)
      else $error("parallel port active while deselected");

   a_frame_evt: assert property (
      fs_fall |=> frame_start && irq_stat_reg[EVT_FRAME])
      else $error("frame start not flagged");

   a_rd_gate: assert property (
      (sync2_reg.rd_n || ser_bit) |-> !pin_out.data_oe)
      else $error("data driven without read low");

   // reference taken from the raw pin, two synchroniser stages back
   a_serial_data_out_b_sel: assert property (
      pin_out.serial_data_out_b_oe == (ser_bit && $past(host_pins.sel_b, 2)))
      else $error("serial output b enable wrong");

   a_hiz_idle: assert property (
      !par_en |-> !pin_out.data_oe)
      else $error("data pins driven while interface disabled");

endmodule

// [sim/csrs_host_model.sv]
// host-side partner: drives the select, read-enable and serial-select pins
module csrs_host_model (
   // clock from the bench
   input wire logic hclk,
   // pins towards the block
   output csrs_pkg::csrs_host_pins_t host_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   import csrs_pkg::*;

   // pins rest high, as the board pull-ups leave them
   initial host_pins = PINS_IDLE;

   // hold sets the pace: short for a prompt host, long for a slow one
   // sel_a stays high, since output A goes dark otherwise
   task automatic drive(input logic cs_n, input logic rd_n, input logic sel_b, input int hold);
      @(posedge hclk);
      host_pins <= '{select_or_frame_sync_in_n: cs_n, rd_n: rd_n, sel_a: 1'b1, sel_b: sel_b};
      repeat (hold) @(posedge hclk);
   endtask
endmodule

// [sim/tb_conversion_status_and_read_select.sv]
// testbench of the status pin, select, read-enable and serial-select block
module tb_conversion_status_and_read_select;
   timeunit 1ns;
   timeprecision 100ps;
   import csrs_pkg::*;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   csrs_core_evt_t core_evt;
   logic [DATA_W-1:0] result_data;
   csrs_host_pins_t host_pins;
   csrs_pin_out_t pin_out;
   logic [DATA_W-1:0] data_out;
   logic frame_start;
   logic irq;
   logic [31:0] rd;
   logic [7:0] ofs [4] = '{CTRL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, 8'h10};
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;

   csrs_top i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_evt(core_evt),
      .result_data(result_data), .host_pins(host_pins), .pin_out(pin_out),
      .data_out(data_out), .frame_start(frame_start), .irq(irq)
   );

   csrs_host_model i_host (
      .hclk(hclk),
      .host_pins(host_pins)
   );

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // runaway guard, well above the few hundred cycles the tests need
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one single AHB transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      // let the edge settle before the caller looks at outputs
      @(negedge hclk);
   endtask

   task automatic evt(input logic [2:0] e);
      @(posedge hclk);
      core_evt <= e;
      @(posedge hclk);
      core_evt <= 3'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      core_evt = 3'h0;
      result_data = 16'hA5C3;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ofs[i]) begin
         ahb(1'b0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      ahb(1'b0, STAT_OFS, 32'h0);
      chk(rd, 32'h78);
      chk(hresp, 1'b0);
      $display("test reset done");
      // busy behaviour, polarity normal
      evt(3'h4);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b1);
      repeat (20) @(posedge hclk);
      chk(pin_out.status_out, 1'b1);
      evt(3'h1);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b0);
      evt(3'h2);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b0);
      $display("test busy done");
      // sequential pairs: one dip of one conversion clock period
      ahb(1'b1, CTRL_OFS, 32'h4);
      evt(3'h4);
      repeat (3) @(posedge hclk);
      evt(3'h2);
      n = 0;
      repeat (20) begin
         @(negedge hclk);
         if (pin_out.status_out === 1'b0) n++;
      end
      chk(n, CCLK_CYCLES_I);
      chk(pin_out.status_out, 1'b1);
      evt(3'h1);
      $display("test sequential done");
      // inverted polarity in busy behaviour
      ahb(1'b1, CTRL_OFS, 32'h2);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b1);
      evt(3'h4);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b0);
      evt(3'h1);
      $display("test polarity done");
      // interrupt behaviour, held until the host reads
      i_host.drive(1'b0, 1'b0, 1'b1, 6);
      i_host.drive(1'b1, 1'b1, 1'b1, 4);
      ahb(1'b1, IRQ_STAT_OFS, 32'h7);
      ahb(1'b1, IRQ_MASK_OFS, 32'h1);
      ahb(1'b1, CTRL_OFS, 32'h1);
      evt(3'h4);
      chk(pin_out.status_out, 1'b0);
      evt(3'h1);
      repeat (3) @(posedge hclk);
      chk(pin_out.status_out, 1'b1);
      chk(irq, 1'b1);
      repeat (10) @(posedge hclk);
      chk(pin_out.status_out, 1'b1);
      i_host.drive(1'b0, 1'b0, 1'b1, 6);
      i_host.drive(1'b1, 1'b1, 1'b1, 4);
      chk(pin_out.status_out, 1'b0);
      ahb(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h5);
      ahb(1'b1, IRQ_MASK_OFS, 32'h0);
      chk(irq, 1'b0);
      ahb(1'b1, IRQ_STAT_OFS, 32'h5);
      ahb(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      $display("test interrupt done");
      // parallel read gating by select and read enable
      ahb(1'b1, CTRL_OFS, 32'h0);
      i_host.drive(1'b1, 1'b0, 1'b1, 6);
      chk(pin_out.data_oe, 1'b0);
      i_host.drive(1'b0, 1'b0, 1'b1, 6);
      chk(pin_out.data_oe, 1'b1);
      chk(data_out, 32'h0000A5C3);
      i_host.drive(1'b0, 1'b1, 1'b1, 6);
      chk(pin_out.data_oe, 1'b0);
      $display("test parallel done");
      // serial: frame sync edge and output selects
      ahb(1'b1, CTRL_OFS, 32'h8);
      ahb(1'b1, IRQ_STAT_OFS, 32'h7);
      i_host.drive(1'b1, 1'b1, 1'b1, 4);
      chk(pin_out.serial_data_out_a_oe, 1'b1);
      chk(pin_out.serial_data_out_b_oe, 1'b1);
      i_host.drive(1'b0, 1'b1, 1'b1, 0);
      n = 0;
      repeat (8) begin
         @(negedge hclk);
         if (frame_start === 1'b1) n++;
      end
      chk(n, 1);
      chk(pin_out.data_oe, 1'b0);
      ahb(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h2);
      i_host.drive(1'b1, 1'b1, 1'b0, 4);
      chk(pin_out.serial_data_out_b_oe, 1'b0);
      $display("test serial done");
      conclude();
   end
endmodule
